/* rtl/sp_ctrl.sv */
// master/slave byte serial port with apb register access
// assumes apb master on pclk; pins resolved outside from output enables
`timescale 1ns/1ps
`default_nettype none
module sp_ctrl
  import sp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  output logic event_o
);
  // ==========================================================
  // helpers
  function automatic logic bit_out(input logic [7:0] v, input logic lsbf);
    bit_out = lsbf ? v[0] : v[7];
  endfunction : bit_out

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsbf);
    shift_in = lsbf ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_STAT) || (a == OFS_RX) || (a == OFS_TX) ||
             (a == OFS_DIV) || (a == OFS_CTRL);
  endfunction : mapped

  // ==========================================================
  // declarations
  sp_pin_if pins ();
  logic [15:0] ctrl_reg;
  logic [7:0] div_reg;
  logic [7:0] tx_reg;
  logic [7:0] last_reg;
  logic [7:0] rx_reg;
  logic [7:0] sr_reg;
  logic tx_valid_reg;
  logic urf_reg;
  logic rx_full_reg;
  logic ovf_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [16:0] acc_reg;
  logic [7:0] hc_reg;
  logic [3:0] h_reg;
  logic [2:0] bcnt_reg;
  logic [3:0] stall_reg;
  sp_state_e state_reg;
  logic out_reg;
  logic sclk_prev_reg;
  logic ss_prev_reg;
  logic sclk_o_reg;
  logic sclk_oe_reg;
  logic mosi_oe_reg;
  logic miso_oe_reg;
  logic ss_n_o_reg;
  logic ss_n_oe_reg;
  logic event_reg;

  logic en, mst, cpha, cpol, lsbf, tim, urm, ovw, ssen, soe, lpbk, cont;
  logic apb_acc, apb_done, wr_tx, rx_rd;
  logic [16:0] acc_sum;
  logic ref_tick;
  logic m_half, m_samp, m_bnd, m_last, m_go, m_more;
  logic s_act, s_edge, s_lead, s_samp, s_shift, s_start;
  logic samp, inbit, byte_done, load, load_first;
  logic [7:0] load_val;
  logic [7:0] sr_shift;
  logic [7:0] stat;

  sp_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sclk_i(sclk_i),
    .mosi_i(mosi_i),
    .miso_i(miso_i),
    .ss_n_i(ss_n_i),
    .pins(pins)
  );

  assign en = ctrl_reg[B_EN];
  assign mst = ctrl_reg[B_MST];
  assign cpha = ctrl_reg[B_CPHA];
  assign cpol = ctrl_reg[B_CPOL];
  assign lsbf = ctrl_reg[B_LSBF];
  assign tim = ctrl_reg[B_TIM];
  assign urm = ctrl_reg[B_URM];
  assign ovw = ctrl_reg[B_OVW];
  assign ssen = ctrl_reg[B_SSEN];
  assign soe = ctrl_reg[B_SOE];
  assign lpbk = ctrl_reg[B_LOOP];
  assign cont = ctrl_reg[B_CONT];

  // ==========================================================
  // apb slave, one wait state per access
  assign apb_acc = psel && penable;
  assign apb_done = apb_acc && pready_reg;
  assign wr_tx = apb_done && pwrite && (paddr == OFS_TX);
  assign rx_rd = apb_done && !pwrite && (paddr == OFS_RX);
  assign stat = {2'b00, ovf_reg, rx_full_reg | ovf_reg, rx_full_reg, urf_reg,
                 !tx_valid_reg | urf_reg, tx_valid_reg | (state_reg == ST_RUN)};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= apb_acc && !pready_reg;
      pslverr_reg <= apb_acc && !pready_reg && !mapped(paddr);
      if (apb_acc && !pready_reg)
      begin
        unique case (paddr)
          OFS_STAT: prdata_reg <= {24'h000000, stat};
          OFS_RX: prdata_reg <= {24'h000000, rx_reg};
          OFS_DIV: prdata_reg <= {24'h000000, div_reg};
          OFS_CTRL: prdata_reg <= {16'h0000, ctrl_reg};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CTRL_RST;
      div_reg <= DIV_RST;
    end
    else if (apb_done && pwrite)
    begin
      if (paddr == OFS_CTRL)
        ctrl_reg <= pwdata[15:0] & CTRL_MASK;
      if (paddr == OFS_DIV)
        div_reg <= pwdata[7:0];
    end
  end

  // ==========================================================
  // master bit clock: 20.48 mhz ticks from pclk by fraction
  assign acc_sum = acc_reg + 17'(REF_KHZ);
  assign ref_tick = acc_sum >= 17'(CLK_KHZ);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_reg <= 17'h00000;
    // restart per frame, else the first half could be one cycle short of a tick
    else if (state_reg != ST_RUN)
      acc_reg <= 17'h00000;
    else if (ref_tick)
      acc_reg <= acc_sum - 17'(CLK_KHZ);
    else
      acc_reg <= acc_sum;
  end

  assign m_half = (state_reg == ST_RUN) && ref_tick && (hc_reg == div_reg);
  assign m_samp = m_half && !h_reg[0];
  assign m_bnd = m_half && h_reg[0];
  assign m_last = m_bnd && (h_reg == 4'hf);
  assign m_go = (state_reg == ST_IDLE) && en && mst && (tim ? tx_valid_reg : rx_rd);
  assign m_more = m_last && cont && tx_valid_reg;

  // ==========================================================
  // slave edge detection on synchronised pins
  // external select frames slave
  assign s_act = en && !mst && !pins.ss_n;
  assign s_start = s_act && ss_prev_reg;
  assign s_edge = pins.sclk ^ sclk_prev_reg;
  assign s_lead = s_edge && (pins.sclk != cpol);
  assign s_samp = s_act && !s_start && (cpha ? (s_edge && !s_lead) : s_lead);
  assign s_shift = s_act && !s_start && (cpha ? s_lead : (s_edge && !s_lead));

  // ==========================================================
  // shared shifter
  assign samp = m_samp || s_samp;
  assign inbit = lpbk ? out_reg : (mst ? pins.miso : pins.mosi);
  assign sr_shift = shift_in(sr_reg, inbit, lsbf);
  assign byte_done = samp && (bcnt_reg == 3'h7);
  assign load_first = m_go || m_more || s_start;
  assign load = load_first || (s_samp && (bcnt_reg == 3'h7));
  assign load_val = tx_valid_reg ? tx_reg : (urm ? last_reg : 8'h00);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_reg <= 8'h00;
      bcnt_reg <= 3'h0;
      out_reg <= 1'b0;
    end
    else if (!en)
    begin
      bcnt_reg <= 3'h0;
    end
    else
    begin
      if (load)
        sr_reg <= load_val;
      else if (samp)
        sr_reg <= sr_shift;
      if (load_first)
        bcnt_reg <= 3'h0;
      else if (samp)
        bcnt_reg <= bcnt_reg + 3'h1;
      // output only moves on the launch edge, so sampling never races it
      if (load_first)
        out_reg <= bit_out(load_val, lsbf);
      else if (m_bnd || s_shift)
        out_reg <= bit_out(sr_reg, lsbf);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_prev_reg <= pins.sclk;
      ss_prev_reg <= pins.ss_n;
    end
  end

  // ==========================================================
  // master sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      stall_reg <= 4'h0;
    end
    else if (!en || !mst)
      state_reg <= ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          if (m_go)
            state_reg <= ST_RUN;
        ST_RUN:
          if (m_last)
          begin
            if (!cont)
              state_reg <= ST_STALL;
            else if (!m_more)
              state_reg <= ST_IDLE;
            stall_reg <= 4'h0;
          end
        ST_STALL:
          if (stall_reg == 4'(STALL_CYC - 1))
            state_reg <= ST_IDLE;
          else
            stall_reg <= stall_reg + 4'h1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hc_reg <= 8'h00;
      h_reg <= 4'h0;
    end
    else if (state_reg != ST_RUN)
    begin
      hc_reg <= 8'h00;
      h_reg <= 4'h0;
    end
    else if (ref_tick)
    begin
      hc_reg <= m_half ? 8'h00 : hc_reg + 8'h01;
      if (m_half)
        h_reg <= h_reg + 4'h1;
    end
  end

  // ==========================================================
  // holding registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_reg <= 8'h00;
      last_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      urf_reg <= 1'b0;
    end
    else
    begin
      if (load)
        last_reg <= load_val;
      if (wr_tx)
        tx_reg <= pwdata[7:0];
      // a write racing a load still counts as fresh data
      if (wr_tx)
        tx_valid_reg <= 1'b1;
      else if (load)
        tx_valid_reg <= 1'b0;
      if (load && !tx_valid_reg)
        urf_reg <= 1'b1;
      else if (wr_tx)
        urf_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end
    else
    begin
      if (byte_done && (!rx_full_reg || ovw || rx_rd))
        rx_reg <= sr_shift;
      if (byte_done)
        rx_full_reg <= 1'b1;
      else if (rx_rd)
        rx_full_reg <= 1'b0;
      if (byte_done && rx_full_reg && !rx_rd)
        ovf_reg <= 1'b1;
      else if (rx_rd)
        ovf_reg <= 1'b0;
    end
  end

  // ==========================================================
  // pin drivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_o_reg <= 1'b0;
      sclk_oe_reg <= 1'b0;
      mosi_oe_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      ss_n_o_reg <= 1'b1;
      ss_n_oe_reg <= 1'b0;
      event_reg <= 1'b0;
    end
    else
    begin
      sclk_o_reg <= cpol ^ ((state_reg == ST_RUN) && (cpha ? !h_reg[0] : h_reg[0]));
      sclk_oe_reg <= en && mst;
      mosi_oe_reg <= en && mst;
      miso_oe_reg <= en && !mst && soe && !pins.ss_n;
      ss_n_o_reg <= state_reg != ST_RUN;
      ss_n_oe_reg <= en && mst && ssen;
      event_reg <= en && (tim ? (!tx_valid_reg || urf_reg) : (rx_full_reg || ovf_reg));
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign sclk_o = sclk_o_reg;
  assign sclk_oe = sclk_oe_reg;
  assign mosi_o = out_reg;
  assign mosi_oe = mosi_oe_reg;
  assign miso_o = out_reg;
  assign miso_oe = miso_oe_reg;
  assign ss_n_o = ss_n_o_reg;
  assign ss_n_oe = ss_n_oe_reg;
  assign event_o = event_reg;

  // ==========================================================
  // assertions
  sequence s_cont_next;
    (state_reg == ST_RUN) && m_last && cont && tx_valid_reg;
  endsequence
  sequence s_single_end;
    (state_reg == ST_RUN) && m_last && !cont && en && mst;
  endsequence

  property p_cont_hold;
    @(posedge pclk) disable iff (!presetn)
    s_cont_next |=> (state_reg == ST_RUN) ##1 (ss_n_o_reg == 1'b0)[*2];
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("select dropped mid stream");

  property p_stall;
    @(posedge pclk) disable iff (!presetn)
    s_single_end |=> (state_reg == ST_STALL)[*4] ##1 (ss_n_o_reg == 1'b1);
  endproperty
  a_stall: assert property (p_stall) else $error("no stall after single byte");

  property p_soe;
    @(posedge pclk) disable iff (!presetn)
    miso_oe_reg |-> $past(soe) && !$past(mst) && $past(en);
  endproperty
  a_soe: assert property (p_soe) else $error("slave output driven while off");

  property p_ovw;
    @(posedge pclk) disable iff (!presetn)
    byte_done && rx_full_reg && ovw |=> rx_reg == $past(sr_shift);
  endproperty
  a_ovw: assert property (p_ovw) else $error("overwrite did not replace");

  property p_keep;
    @(posedge pclk) disable iff (!presetn)
    byte_done && rx_full_reg && !ovw && !rx_rd |=> $stable(rx_reg) && ovf_reg;
  endproperty
  a_keep: assert property (p_keep) else $error("held byte lost");

  property p_ur_prev;
    @(posedge pclk) disable iff (!presetn)
    load && !tx_valid_reg && urm && !wr_tx |=> sr_reg == $past(last_reg) && urf_reg;
  endproperty
  a_ur_prev: assert property (p_ur_prev) else $error("underflow did not resend");

  property p_ur_zero;
    @(posedge pclk) disable iff (!presetn)
    load && !tx_valid_reg && !urm |=> sr_reg == 8'h00;
  endproperty
  a_ur_zero: assert property (p_ur_zero) else $error("underflow byte not zero");

  property p_start_tx;
    @(posedge pclk) disable iff (!presetn)
    (state_reg == ST_IDLE) && en && mst && tim && tx_valid_reg |=> (state_reg == ST_RUN)
      && (!tx_valid_reg || $past(wr_tx));
  endproperty
  a_start_tx: assert property (p_start_tx) else $error("write did not start");

  property p_off;
    @(posedge pclk) disable iff (!presetn)
    !en [*3] |-> state_reg == ST_IDLE && sclk_o_reg == $past(cpol) && !miso_oe_reg;
  endproperty
  a_off: assert property (p_off) else $error("disabled port not idle");

endmodule : sp_ctrl
`default_nettype wire

/* rtl/sp_pkg.sv */
// constants, field positions and state types of the serial port controller
// assumes a 100 mhz pclk and 32-bit apb access with byte addresses
// Operation
// - continuous master: bytes back to back
// - continuous: select held until transmit empties
// - non-continuous: one 8-bit exchange per transfer
// - non-continuous: stall before next transfer
// - loopback ties data output to input
// - slave output driven only when enabled
// - master select output gated by enable
// - overwrite set: new byte replaces held
// - overwrite clear: new byte dropped
// - underflow mode set: resend previous byte
// - underflow mode clear: send zero byte
// - transmit-start mode: write starts, empty event
// - receive-start mode: read starts, full event
// - bit order bit selects lsb first
// - polarity bit sets clock idle level
// - phase bit: pulse at bit start
// - role bit selects master or slave
// - enable bit gates whole port
// - master clock 20.48 mhz over 2(1+div)
// - pin directions follow role
package sp_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_RX = 8'h04;
  localparam logic [7:0] OFS_TX = 8'h08;
  localparam logic [7:0] OFS_DIV = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  // ==========================================================
  // control fields
  localparam int B_EN = 0;
  localparam int B_MST = 1;
  localparam int B_CPHA = 2;
  localparam int B_CPOL = 3;
  localparam int B_LSBF = 5;
  localparam int B_TIM = 6;
  localparam int B_URM = 7;
  localparam int B_OVW = 8;
  localparam int B_SSEN = 9;
  localparam int B_SOE = 10;
  localparam int B_LOOP = 11;
  localparam int B_CONT = 12;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h1fef;
  localparam logic [7:0] DIV_RST = 8'h1b;
  // ==========================================================
  // timing
  localparam int CLK_NS = 10;
  localparam int CLK_KHZ = 100000;
  localparam int REF_KHZ = 20480;
  localparam int STALL_NS = 50;
  localparam int STALL_CYC = (STALL_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // master sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STALL} sp_state_e;
endpackage : sp_pkg

/* rtl/sp_pin_if.sv */
// synchronised serial pin levels passed from the sampler to the core
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface sp_pin_if;
  logic sclk;
  logic mosi;
  logic miso;
  logic ss_n;
  modport sync (output sclk, output mosi, output miso, output ss_n);
  modport core (input sclk, input mosi, input miso, input ss_n);
endinterface : sp_pin_if
`default_nettype wire

/* rtl/sp_sync.sv */
// two-stage synchronisers for the four serial pin inputs
// assumes the pins are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module sp_sync
  import sp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  sp_pin_if.sync pins
);
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= 4'hf;
      sync_reg <= 4'hf;
    end
    else
    begin
      meta_reg <= {ss_n_i, miso_i, mosi_i, sclk_i};
      sync_reg <= meta_reg;
    end
  end

  assign pins.sclk = sync_reg[0];
  assign pins.mosi = sync_reg[1];
  assign pins.miso = sync_reg[2];
  assign pins.ss_n = sync_reg[3];
endmodule : sp_sync
`default_nettype wire

/* test/sp_far_model.sv */
// behavioural spi slave standing on the far side of the port
// assumes its mode inputs mirror the port's control bits
`timescale 1ns/1ps
`default_nettype none
module sp_far_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsbf,
  input wire logic [7:0] tx_byte,
  output wire logic miso,
  output var logic [7:0] rx_byte,
  output var int rx_count
);
  logic [7:0] sh_in = 8'h00;
  logic [7:0] sh_out = 8'h00;
  logic first = 1'b1;
  int cnt = 0;
  wire logic cur = lsbf ? sh_out[0] : sh_out[7];
  assign miso = ss_n ? ~cur : cur;
  initial
  begin
    rx_byte = 8'h00;
    rx_count = 0;
  end
  always @(negedge ss_n)
  begin
    sh_out = tx_byte;
    cnt = 0;
    first = 1'b1;
  end
  always @(sclk)
  begin
    if (ss_n === 1'b0 && (sclk !== cpol) !== cpha)
    begin
      sh_in = lsbf ? {mosi, sh_in[7:1]} : {sh_in[6:0], mosi};
      cnt++;
      first = 1'b0;
      if (cnt == 8)
      begin
        rx_byte = sh_in;
        rx_count++;
        cnt = 0;
        sh_out = tx_byte;
        first = 1'b1;
      end
    end
    // first bit already presented, so no shift before a sample
    else if (ss_n === 1'b0 && !first)
      sh_out = lsbf ? {1'b0, sh_out[7:1]} : {sh_out[6:0], 1'b0};
  end
endmodule : sp_far_model
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the serial port controller
// assumes sp_far_model as the external slave on the pins
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sp_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, event_o;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
  logic bench_ss_n = 1'b1;
  logic bench_sclk = 1'b0;
  logic bench_mosi = 1'b1;
  logic m_cpol = 1'b0;
  logic m_cpha = 1'b0;
  logic m_lsbf = 1'b0;
  logic [7:0] m_tx = 8'h00;
  logic [7:0] m_rx;
  logic m_miso;
  logic ss_q = 1'b1;
  int m_cnt;
  int err_total = 0;
  int num_checks = 0;
  int ss_rises = 0;
  int hi_run = 0;
  int gap = 0;
  // undriven lines: bench plays the external master, idle clock low, mosi pulled up
  wire logic sclk_w = sclk_oe ? sclk_o : bench_sclk;
  wire logic mosi_w = mosi_oe ? mosi_o : bench_mosi;
  wire logic miso_w = miso_oe ? miso_o : m_miso;
  wire logic ss_w = ss_n_oe ? ss_n_o : bench_ss_n;
  localparam logic [31:0] MST = 32'h243;

  always #(CLK_NS / 2) pclk = ~pclk;

  sp_ctrl DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sclk_i(sclk_w), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w),
    .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe), .event_o(event_o));

  sp_far_model u_far (.sclk(sclk_w), .mosi(mosi_w), .ss_n(ss_w), .cpol(m_cpol),
    .cpha(m_cpha), .lsbf(m_lsbf), .tx_byte(m_tx), .miso(m_miso), .rx_byte(m_rx),
    .rx_count(m_cnt));

  // ==========================================================
  // select framing monitor
  always @(posedge pclk)
  begin
    ss_q <= ss_n_o;
    if (ss_n_o === 1'b1 && ss_q === 1'b0) ss_rises++;
    if (ss_n_o === 1'b0 && ss_q === 1'b1) gap = hi_run;
    hi_run = (ss_n_o === 1'b1) ? hi_run + 1 : 0;
  end

  function automatic logic [31:0] bt(input int b);
    return 32'h1 << b;
  endfunction : bt

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // ==========================================================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    repeat (3) @(posedge pclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  // polls busy, then lets the stall run out
  task automatic wait_done();
    logic [31:0] s;
    repeat (3) @(posedge pclk);
    do
    begin
      rd(OFS_STAT, s);
    end
    while (s[0] !== 1'b0);
    repeat (12) @(posedge pclk);
  endtask : wait_done

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(OFS_CTRL, q);
    chk("ctrl_rst", 32'h0, q);
    rd(OFS_DIV, q);
    chk("div_rst", 32'h1b, q);
    rd(OFS_STAT, q);
    chk("stat_rst", 32'h2, q);
    wr(OFS_CTRL, 32'hffff);
    rd(OFS_CTRL, q);
    chk("ctrl_mask", 32'h1fef, q);
    wr(OFS_CTRL, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    wr(OFS_DIV, 32'h0);
  endtask : t_regs

  task automatic t_modes();
    logic [31:0] q;
    logic [7:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b = 8'h3a ^ 8'(i * 37);
      {m_lsbf, m_cpha, m_cpol} = 3'(i);
      m_tx = ~b;
      q = MST | (32'(m_cpol) << B_CPOL) | (32'(m_cpha) << B_CPHA);
      wr(OFS_CTRL, q | (32'(m_lsbf) << B_LSBF));
      chk("sclk_idle", {31'h0, m_cpol}, {31'h0, sclk_o});
      chk("oe_master", 32'h6, {29'h0, sclk_oe, mosi_oe, miso_oe});
      wr(OFS_TX, {24'h0, b});
      wait_done();
      chk("far_rx", {24'h0, b}, {24'h0, m_rx});
      rd(OFS_RX, q);
      chk("rx_data", {24'h0, ~b}, q);
      chk("event_tx", 32'h1, {31'h0, event_o});
    end
    {m_lsbf, m_cpha, m_cpol} = 3'h0;
  endtask : t_modes

  task automatic t_cont();
    int c0;
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_CTRL, MST | (32'(i) << B_CONT));
      ss_rises = 0;
      c0 = m_cnt;
      wr(OFS_TX, 32'h81);
      wr(OFS_TX, 32'h42);
      wait_done();
      chk("far_count", 32'(c0 + 2), 32'(m_cnt));
      chk("far_last", 32'h42, {24'h0, m_rx});
      chk("ss_frames", 32'(2 - i), 32'(ss_rises));
      if (i == 0) chk("stall_gap", 32'h1, 32'(gap >= STALL_CYC));
    end
  endtask : t_cont

  task automatic t_under();
    logic [31:0] q;
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_CTRL, bt(B_EN) | bt(B_MST) | bt(B_SSEN) | (32'(i) << B_URM));
      wr(OFS_TX, 32'h5a);
      rd(OFS_RX, q);
      wait_done();
      chk("rd_start", 32'h5a, {24'h0, m_rx});
      chk("event_rx", 32'h1, {31'h0, event_o});
      rd(OFS_RX, q);
      wait_done();
      chk("underflow", (i == 1) ? 32'h5a : 32'h0, {24'h0, m_rx});
    end
  endtask : t_under

  task automatic t_ovw();
    logic [31:0] q;
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_CTRL, MST | (32'(i) << B_OVW));
      rd(OFS_RX, q);
      m_tx = 8'h11;
      wr(OFS_TX, 32'h0);
      wait_done();
      m_tx = 8'h22;
      wr(OFS_TX, 32'h0);
      wait_done();
      rd(OFS_RX, q);
      chk("rx_overrun", (i == 1) ? 32'h22 : 32'h11, q);
    end
  endtask : t_ovw

  task automatic t_loop();
    logic [31:0] q;
    wr(OFS_CTRL, MST | bt(B_LOOP));
    m_tx = 8'h00;
    wr(OFS_TX, 32'hc3);
    wait_done();
    rd(OFS_RX, q);
    chk("loopback", 32'hc3, q);
  endtask : t_loop

  task automatic t_pins();
    wr(OFS_CTRL, bt(B_EN) | bt(B_MST));
    chk("ss_oe_off", 32'h0, {31'h0, ss_n_oe});
    wr(OFS_CTRL, bt(B_EN) | bt(B_MST) | bt(B_SSEN));
    chk("ss_oe_on", 32'h1, {31'h0, ss_n_oe});
    wr(OFS_CTRL, bt(B_EN) | bt(B_SOE));
    bench_ss_n <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("slave_oe", 32'h1, {29'h0, sclk_oe, mosi_oe, miso_oe});
    wr(OFS_CTRL, bt(B_EN));
    chk("slave_oe_off", 32'h0, {31'h0, miso_oe});
    wr(OFS_CTRL, bt(B_SOE));
    chk("disabled", 32'h0, {28'h0, sclk_oe, miso_oe, event_o, ss_n_oe});
    chk("disabled_idle", 32'h1, {31'h0, ss_n_o});
    bench_ss_n <= 1'b1;
  endtask : t_pins

  // slave role, mode 0, msb first: bench clocks one byte in and out
  task automatic t_slave();
    logic [31:0] q;
    logic [7:0] v;
    logic [7:0] g;
    v = 8'h3c;
    g = 8'h00;
    wr(OFS_CTRL, bt(B_EN) | bt(B_SOE));
    wr(OFS_TX, 32'ha5);
    bench_ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      bench_mosi <= v[i];
      repeat (8) @(posedge pclk);
      g[i] = miso_w;
      bench_sclk <= 1'b1;
      repeat (8) @(posedge pclk);
      bench_sclk <= 1'b0;
    end
    repeat (8) @(posedge pclk);
    bench_ss_n <= 1'b1;
    bench_mosi <= 1'b1;
    rd(OFS_RX, q);
    chk("slave_rx", 32'h3c, q);
    chk("slave_tx", 32'ha5, {24'h0, g});
  endtask : t_slave

  // divider 3: fifteen halves of (3+1) reference ticks each
  task automatic t_rate();
    int c, k, n, ex;
    logic s;
    c = 0;
    k = 0;
    n = 0;
    ex = 15 * 4 * CLK_KHZ / REF_KHZ;
    wr(OFS_DIV, 32'h3);
    wr(OFS_CTRL, MST);
    s = sclk_o;
    wr(OFS_TX, 32'h96);
    while (k < 16 && n < 3000)
    begin
      @(posedge pclk);
      n++;
      if (k > 0) c++;
      if (sclk_o !== s) k++;
      s = sclk_o;
    end
    chk("sclk_rate", 32'h1, 32'(c >= ex - 2 && c <= ex + 3));
    wait_done();
  endtask : t_rate

  task automatic final_report();
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_modes();
    t_cont();
    t_under();
    t_ovw();
    t_loop();
    t_pins();
    t_slave();
    t_rate();
    final_report();
  end

  initial
  begin
    repeat (60000) @(posedge pclk);
    err_total++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
